// ### rtl/core_debug_trigger_trace.sv
// design: breakpoint triggers, serial debug access and real-time trace outputs
`timescale 1ns/1ps
`default_nettype none
module core_debug_trigger_trace (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // package option: trace buses bonded out
  input wire logic FULL_TRACE_PKG,
  // observed processor activity
  input wire dbg_pkg::cpu_obs_t CPU_OBS,
  input wire logic CPU_CRIT_IRQ,
  // supervisor access
  input wire logic SUP_WR,
  input wire logic SUP_MODE,
  input wire logic [3:0] SUP_IDX,
  input wire logic [31:0] SUP_WDATA,
  output logic [31:0] SUP_RDATA,
  // trigger actions
  output logic CPU_HALT,
  output logic DEBUG_IRQ,
  output logic CRIT_IRQ_ALLOW,
  input wire logic DEBUG_IRQ_DONE,
  input wire logic HALT_RELEASE,
  // serial debug channel
  input wire logic DEBUG_SERIAL_IN,
  input wire logic DEBUG_SERIAL_CLOCK,
  output logic DEBUG_SERIAL_OUT,
  // trace outputs
  output logic [3:0] PROCESSOR_STATUS_BUS,
  output logic [3:0] DEBUG_DATA_BUS,
  output logic TRACE_CLOCK_OUT,
  output logic ALL_STATUS_HIGH
);
  // ==========================================
  // breakpoint registers
  logic [31:0] bkpt_reg [0:8];
  logic [9:0] ctrl_reg;
  logic ser_wr;
  logic [3:0] ser_idx;
  logic [31:0] ser_wdata;

  function automatic logic masked_eq(input logic [31:0] a, input logic [31:0] b, input logic [31:0] m);
    masked_eq = ((a ^ b) & m) == 32'h0000_0000;
  endfunction : masked_eq

  function automatic logic [31:0] read_idx(input logic [3:0] idx);
    if (idx < dbg_pkg::BKPT_COUNT) begin
      read_idx = bkpt_reg[idx];
    end else if (idx == dbg_pkg::IDX_TRIG_CTRL) begin
      read_idx = {22'h0, ctrl_reg};
    end else begin
      read_idx = 32'h0000_0000;
    end
  endfunction : read_idx

  // serial writes win over supervisor writes in the same cycle
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < 9; i++) begin
        bkpt_reg[i] <= ((i == 1) || (i == 3) || (i == 8)) ? dbg_pkg::MASK_RESET : dbg_pkg::BKPT_RESET;
      end
      ctrl_reg <= 10'h000;
    end else if (ser_wr) begin
      if (ser_idx < dbg_pkg::BKPT_COUNT) begin
        bkpt_reg[ser_idx] <= ser_wdata;
      end else if (ser_idx == dbg_pkg::IDX_TRIG_CTRL) begin
        ctrl_reg <= ser_wdata[9:0];
      end
    end else if (SUP_WR && SUP_MODE) begin
      if (SUP_IDX < dbg_pkg::BKPT_COUNT) begin
        bkpt_reg[SUP_IDX] <= SUP_WDATA;
      end else if (SUP_IDX == dbg_pkg::IDX_TRIG_CTRL) begin
        ctrl_reg <= SUP_WDATA[9:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      SUP_RDATA <= 32'h0000_0000;
    end else begin
      SUP_RDATA <= SUP_MODE ? read_idx(SUP_IDX) : 32'h0000_0000;
    end
  end

  // ==========================================
  // trigger evaluation
  logic addr_hit;
  logic data_hit;
  logic pc_hit;
  logic lvl1_hit;
  logic lvl2_hit;
  assign addr_hit = masked_eq(CPU_OBS.addr, bkpt_reg[dbg_pkg::IDX_ADDR], ~bkpt_reg[dbg_pkg::IDX_ADDR_MASK]);
  assign data_hit = masked_eq(CPU_OBS.data, bkpt_reg[dbg_pkg::IDX_DATA], ~bkpt_reg[dbg_pkg::IDX_DATA_MASK]);
  always_comb begin
    pc_hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      pc_hit = pc_hit | masked_eq(CPU_OBS.pc, bkpt_reg[4 + i], ~bkpt_reg[dbg_pkg::IDX_PC_MASK]);
    end
  end
  // each level needs every selected condition; a level with none selected never fires
  assign lvl1_hit = CPU_OBS.valid && (ctrl_reg[2:0] != 3'b000) && (addr_hit || !ctrl_reg[dbg_pkg::CTL_L1_ADDR])
    && (data_hit || !ctrl_reg[dbg_pkg::CTL_L1_DATA]) && (pc_hit || !ctrl_reg[dbg_pkg::CTL_L1_PC]);
  assign lvl2_hit = CPU_OBS.valid && (ctrl_reg[5:3] != 3'b000) && (addr_hit || !ctrl_reg[dbg_pkg::CTL_L2_ADDR])
    && (data_hit || !ctrl_reg[dbg_pkg::CTL_L2_DATA]) && (pc_hit || !ctrl_reg[dbg_pkg::CTL_L2_PC]);

  dbg_pkg::trig_state_t trig_reg;
  logic fire;
  always_comb begin
    fire = 1'b0;
    case (trig_reg)
      dbg_pkg::TRIG_IDLE: fire = lvl1_hit && !ctrl_reg[dbg_pkg::CTL_DUAL];
      dbg_pkg::TRIG_ARMED2: fire = lvl2_hit;
      default: fire = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      trig_reg <= dbg_pkg::TRIG_IDLE;
    end else if (!ctrl_reg[dbg_pkg::CTL_ENABLE]) begin
      trig_reg <= dbg_pkg::TRIG_IDLE;
    end else begin
      case (trig_reg)
        dbg_pkg::TRIG_IDLE: begin
          if (fire) begin
            trig_reg <= ctrl_reg[dbg_pkg::CTL_ACTION_IRQ] ? dbg_pkg::TRIG_IRQ : dbg_pkg::TRIG_HALT;
          end else if (lvl1_hit && ctrl_reg[dbg_pkg::CTL_DUAL]) begin
            trig_reg <= dbg_pkg::TRIG_ARMED2;
          end
        end
        dbg_pkg::TRIG_ARMED2: begin
          if (fire) begin
            trig_reg <= ctrl_reg[dbg_pkg::CTL_ACTION_IRQ] ? dbg_pkg::TRIG_IRQ : dbg_pkg::TRIG_HALT;
          end
        end
        dbg_pkg::TRIG_HALT: begin
          if (HALT_RELEASE) begin
            trig_reg <= dbg_pkg::TRIG_IDLE;
          end
        end
        dbg_pkg::TRIG_IRQ: begin
          if (DEBUG_IRQ_DONE) begin
            trig_reg <= dbg_pkg::TRIG_IDLE;
          end
        end
        default: trig_reg <= dbg_pkg::TRIG_IDLE;
      endcase
    end
  end

  assign CPU_HALT = (trig_reg == dbg_pkg::TRIG_HALT);
  assign DEBUG_IRQ = (trig_reg == dbg_pkg::TRIG_IRQ);
  assign CRIT_IRQ_ALLOW = DEBUG_IRQ && ctrl_reg[dbg_pkg::CTL_ALLOW_RT_IRQ] && CPU_CRIT_IRQ;

  // ==========================================
  // serial channel: three-flop sampling, edges once flops two and three agree
  logic [2:0] clk_sync;
  logic [2:0] din_sync;
  logic sclk_state;
  logic sclk_rise;
  logic sclk_fall;
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      clk_sync <= 3'b000;
      din_sync <= 3'b000;
      sclk_state <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[1:0], DEBUG_SERIAL_CLOCK};
      din_sync <= {din_sync[1:0], DEBUG_SERIAL_IN};
      if (clk_sync[2] == clk_sync[1]) begin
        sclk_state <= clk_sync[2];
      end
    end
  end
  assign sclk_rise = (clk_sync[2] == clk_sync[1]) && clk_sync[2] && !sclk_state;
  assign sclk_fall = (clk_sync[2] == clk_sync[1]) && !clk_sync[2] && sclk_state;

  dbg_pkg::ser_state_t ser_reg;
  logic [36:0] shift_reg;
  logic [5:0] bit_cnt_reg;
  logic [31:0] reply_reg;
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ser_reg <= dbg_pkg::SER_SHIFT;
      shift_reg <= 37'h0;
      bit_cnt_reg <= 6'h00;
      reply_reg <= 32'h0000_0000;
      DEBUG_SERIAL_OUT <= 1'b0;
    end else begin
      case (ser_reg)
        dbg_pkg::SER_SHIFT: begin
          if (sclk_fall) begin
            DEBUG_SERIAL_OUT <= reply_reg[31];
            reply_reg <= {reply_reg[30:0], 1'b0};
          end
          if (sclk_rise) begin
            shift_reg <= {shift_reg[35:0], din_sync[2]};
            if (bit_cnt_reg == dbg_pkg::FRAME_BITS - 6'h01) begin
              bit_cnt_reg <= 6'h00;
              ser_reg <= dbg_pkg::SER_EXEC;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
          end
        end
        dbg_pkg::SER_EXEC: begin
          ser_reg <= dbg_pkg::SER_REPLY;
        end
        dbg_pkg::SER_REPLY: begin
          reply_reg <= read_idx(shift_reg[35:32]);
          ser_reg <= dbg_pkg::SER_SHIFT;
        end
        default: ser_reg <= dbg_pkg::SER_SHIFT;
      endcase
    end
  end
  assign ser_wr = (ser_reg == dbg_pkg::SER_EXEC) && shift_reg[36];
  assign ser_idx = shift_reg[35:32];
  assign ser_wdata = shift_reg[31:0];

  // ==========================================
  // trace: two-entry buffer between event capture and nibble serialiser
  dbg_pkg::trace_word_t buf_mem [0:1];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic in_valid;
  logic in_ready;
  logic out_valid;
  logic out_ready;
  dbg_pkg::trace_word_t in_word;
  assign in_valid = CPU_OBS.valid && !CPU_HALT;
  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  always_comb begin
    in_word.status = CPU_OBS.branch ? dbg_pkg::PST_TAKEN : dbg_pkg::PST_BEGIN_INSN;
    in_word.payload = CPU_OBS.branch ? CPU_OBS.addr : CPU_OBS.data;
    in_word.nibbles = 3'h7;
  end
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (in_valid && in_ready) begin
        buf_mem[wr_ptr_reg] <= in_word;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (out_valid && out_ready) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready};
    end
  end

  logic [31:0] nib_reg;
  logic [2:0] nib_left_reg;
  logic busy_reg;
  logic [3:0] status_reg;
  logic [3:0] ddata_reg;
  // hold buffered words while halted so none is popped unseen
  assign out_ready = !busy_reg && !CPU_HALT;
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      busy_reg <= 1'b0;
      nib_reg <= 32'h0000_0000;
      nib_left_reg <= 3'h0;
      status_reg <= dbg_pkg::PST_CONTINUE;
      ddata_reg <= 4'h0;
    end else if (CPU_HALT) begin
      status_reg <= dbg_pkg::PST_HALTED;
      ddata_reg <= 4'h0;
    end else if (busy_reg) begin
      status_reg <= dbg_pkg::PST_OPERAND;
      ddata_reg <= nib_reg[3:0];
      nib_reg <= {4'h0, nib_reg[31:4]};
      nib_left_reg <= nib_left_reg - 3'h1;
      busy_reg <= (nib_left_reg != 3'h0);
    end else if (out_valid) begin
      status_reg <= buf_mem[rd_ptr_reg].status;
      ddata_reg <= buf_mem[rd_ptr_reg].payload[3:0];
      nib_reg <= {4'h0, buf_mem[rd_ptr_reg].payload[31:4]};
      nib_left_reg <= buf_mem[rd_ptr_reg].nibbles - 3'h1;
      busy_reg <= 1'b1;
    end else begin
      status_reg <= DEBUG_IRQ ? dbg_pkg::PST_DEBUG_IRQ : dbg_pkg::PST_CONTINUE;
      ddata_reg <= 4'h0;
    end
  end

  // trace clock runs at cpu rate; buses silent when not bonded out
  assign TRACE_CLOCK_OUT = FULL_TRACE_PKG & SYS_CLK;
  assign PROCESSOR_STATUS_BUS = FULL_TRACE_PKG ? status_reg : 4'h0;
  assign DEBUG_DATA_BUS = FULL_TRACE_PKG ? ddata_reg : 4'h0;
  assign ALL_STATUS_HIGH = &status_reg;
endmodule : core_debug_trigger_trace
`default_nettype wire

// ### inc/dbg_pkg.sv
// package: constants and types for the debug trigger and trace block
`default_nettype none
package dbg_pkg;
  // ==========================================
  // breakpoint register indices
  localparam logic [3:0] BKPT_COUNT = 4'h9;
  localparam logic [3:0] IDX_ADDR = 4'h0;
  localparam logic [3:0] IDX_ADDR_MASK = 4'h1;
  localparam logic [3:0] IDX_DATA = 4'h2;
  localparam logic [3:0] IDX_DATA_MASK = 4'h3;
  localparam logic [3:0] IDX_PC0 = 4'h4;
  localparam logic [3:0] IDX_PC1 = 4'h5;
  localparam logic [3:0] IDX_PC2 = 4'h6;
  localparam logic [3:0] IDX_PC3 = 4'h7;
  localparam logic [3:0] IDX_PC_MASK = 4'h8;
  // index 4'ha: trigger control (not a breakpoint register)
  localparam logic [3:0] IDX_TRIG_CTRL = 4'ha;
  // trigger control field positions
  localparam int CTL_L1_ADDR = 0;
  localparam int CTL_L1_DATA = 1;
  localparam int CTL_L1_PC = 2;
  localparam int CTL_L2_ADDR = 3;
  localparam int CTL_L2_DATA = 4;
  localparam int CTL_L2_PC = 5;
  localparam int CTL_DUAL = 6;
  localparam int CTL_ACTION_IRQ = 7;
  localparam int CTL_ENABLE = 8;
  localparam int CTL_ALLOW_RT_IRQ = 9;
  // reset values
  localparam logic [31:0] BKPT_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'hffff_ffff;
  // ==========================================
  // serial frame: 1 write flag, 4 index bits, 32 data bits
  localparam logic [5:0] FRAME_BITS = 6'h25;
  // ==========================================
  // status codes on the processor status bus
  localparam logic [3:0] PST_CONTINUE = 4'h0;
  localparam logic [3:0] PST_BEGIN_INSN = 4'h1;
  localparam logic [3:0] PST_TAKEN = 4'h5;
  localparam logic [3:0] PST_OPERAND = 4'h8;
  localparam logic [3:0] PST_DEBUG_IRQ = 4'hc;
  localparam logic [3:0] PST_HALTED = 4'hf;
  // ==========================================
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [31:0] pc;
    logic valid;
    logic branch;
  } cpu_obs_t;
  typedef struct packed {
    logic [3:0] status;
    logic [31:0] payload;
    logic [2:0] nibbles;
  } trace_word_t;
  typedef enum logic [1:0] {
    TRIG_IDLE = 2'b00,
    TRIG_ARMED2 = 2'b01,
    TRIG_HALT = 2'b10,
    TRIG_IRQ = 2'b11
  } trig_state_t;
  typedef enum logic [1:0] {
    SER_SHIFT = 2'b00,
    SER_EXEC = 2'b01,
    SER_REPLY = 2'b10
  } ser_state_t;
endpackage : dbg_pkg
`default_nettype wire

// ### verification/core_debug_trigger_trace_sva.sv
// checker: port properties of the debug trigger and trace block
`timescale 1ns/1ps
`default_nettype none
module core_debug_trigger_trace_sva (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // watched ports
  input wire logic FULL_TRACE_PKG,
  input wire dbg_pkg::cpu_obs_t CPU_OBS,
  input wire logic CPU_CRIT_IRQ,
  input wire logic SUP_MODE,
  input wire logic [3:0] SUP_IDX,
  input wire logic [31:0] SUP_RDATA,
  input wire logic CPU_HALT,
  input wire logic DEBUG_IRQ,
  input wire logic CRIT_IRQ_ALLOW,
  input wire logic HALT_RELEASE,
  input wire logic [3:0] PROCESSOR_STATUS_BUS,
  input wire logic [3:0] DEBUG_DATA_BUS,
  input wire logic ALL_STATUS_HIGH
);
  default clocking dc @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);
  // =====
  // properties
  chk_status_and: assert property (FULL_TRACE_PKG && $past(FULL_TRACE_PKG) |->
    ALL_STATUS_HIGH == &PROCESSOR_STATUS_BUS) else $error("combined status wrong");
  chk_trace_off: assert property (!FULL_TRACE_PKG && !$past(FULL_TRACE_PKG) |->
    PROCESSOR_STATUS_BUS == 4'h0 && DEBUG_DATA_BUS == 4'h0) else $error("trace not gated");
  chk_halt_shows: assert property ($rose(CPU_HALT) |=> ALL_STATUS_HIGH)
    else $error("halt not shown");
  chk_one_action: assert property (!(CPU_HALT && DEBUG_IRQ))
    else $error("halt and irq together");
  chk_halt_cause: assert property ($rose(CPU_HALT) |-> $past(CPU_OBS.valid))
    else $error("halt without event");
  chk_irq_cause: assert property ($rose(DEBUG_IRQ) |-> $past(CPU_OBS.valid))
    else $error("irq without event");
  chk_halt_ends: assert property (CPU_HALT && HALT_RELEASE && !CPU_OBS.valid |=> !CPU_HALT)
    else $error("halt not released");
  chk_crit_gate: assert property (CRIT_IRQ_ALLOW |-> DEBUG_IRQ && CPU_CRIT_IRQ)
    else $error("critical irq allowed wrongly");
  chk_sup_locked: assert property (!$past(SUP_MODE) |-> SUP_RDATA == 32'h0)
    else $error("read without supervisor");
  chk_unmapped_read: assert property ($past(SUP_IDX) == 4'h9 || $past(SUP_IDX) > 4'ha |->
    SUP_RDATA == 32'h0) else $error("unmapped read not zero");
  cov_halt: cover property ($rose(CPU_HALT));
  cov_irq: cover property ($rose(DEBUG_IRQ));
  cov_crit: cover property (CRIT_IRQ_ALLOW);
endmodule : core_debug_trigger_trace_sva
bind core_debug_trigger_trace core_debug_trigger_trace_sva i_chk (.*);
`default_nettype wire

// ### verification/debug_host_model.sv
// partner: external debug tool on the serial debug channel
`timescale 1ns/1ps
`default_nettype none
module debug_host_model (
  // serial channel
  output logic debug_serial_clock,
  output logic debug_serial_in,
  input wire logic debug_serial_out
);
  logic [36:0] frame;
  initial begin
    debug_serial_clock = 1'b0;
    debug_serial_in = 1'b1;
  end
  // one frame out, reply of the previous frame in; clock idles low
  task automatic xfer(input logic wr, input logic [3:0] idx, input logic [31:0] d,
    output logic [31:0] r);
    r = 32'h0;
    frame = {wr, idx, d};
    #1.3;
    for (int i = 36; i >= 0; i--) begin
      debug_serial_in = frame[i];
      #62.5 debug_serial_clock = 1'b1;
      if (i > 4) begin
        r = {r[30:0], debug_serial_out};
      end
      #62.5 debug_serial_clock = 1'b0;
    end
    debug_serial_in = ~frame[0];
    #200;
  endtask : xfer
endmodule : debug_host_model
`default_nettype wire

// ### verification/tb_core_debug_trigger_trace.sv
// testbench: self-checking run of the debug trigger and trace block
`timescale 1ns/1ps
`default_nettype none
module tb_core_debug_trigger_trace;
  typedef struct {string n; logic [31:0] v;} note_t;
  logic SYS_CLK = 1'b0;
  logic RESET = 1'b1;
  logic FULL_TRACE_PKG = 1'b1;
  dbg_pkg::cpu_obs_t CPU_OBS = '0;
  logic CPU_CRIT_IRQ = 1'b0;
  logic SUP_WR = 1'b0;
  logic SUP_MODE = 1'b1;
  logic [3:0] SUP_IDX = 4'h0;
  logic [31:0] SUP_WDATA = 32'h0;
  logic DEBUG_IRQ_DONE = 1'b0;
  logic HALT_RELEASE = 1'b0;
  wire logic DEBUG_SERIAL_CLOCK, DEBUG_SERIAL_IN;
  logic [31:0] SUP_RDATA;
  logic CPU_HALT, DEBUG_IRQ, CRIT_IRQ_ALLOW, DEBUG_SERIAL_OUT, TRACE_CLOCK_OUT, ALL_STATUS_HIGH;
  logic [3:0] PROCESSOR_STATUS_BUS, DEBUG_DATA_BUS;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  note_t q[$];
  note_t nt;
  logic [31:0] seen;
  event shown;
  always #5 SYS_CLK = ~SYS_CLK;
  core_debug_trigger_trace i_dut (.*);
  debug_host_model i_host (.debug_serial_clock(DEBUG_SERIAL_CLOCK), .debug_serial_in(DEBUG_SERIAL_IN),
    .debug_serial_out(DEBUG_SERIAL_OUT));
  // =====
  // shared tasks
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic note(string n, logic [31:0] e, logic [31:0] s);
    q.push_back('{n, e});
    seen = s;
    -> shown;
    #1;
  endtask : note
  initial forever begin
    @(shown);
    nt = q.pop_front();
    check(nt.n, seen, nt.v);
  end
  task automatic wr(logic [3:0] i, logic [31:0] d);
    @(negedge SYS_CLK);
    SUP_WR = 1'b1;
    SUP_IDX = i;
    SUP_WDATA = d;
    @(negedge SYS_CLK);
    SUP_WR = 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] i, output logic [31:0] r);
    @(negedge SYS_CLK);
    SUP_IDX = i;
    @(negedge SYS_CLK);
    r = SUP_RDATA;
  endtask : rd
  task automatic ev(logic [31:0] a, logic [31:0] d, logic [31:0] p);
    @(negedge SYS_CLK);
    CPU_OBS = '{a, d, p, 1'b1, 1'b0};
    @(negedge SYS_CLK);
    CPU_OBS.valid = 1'b0;
    repeat (2) @(negedge SYS_CLK);
  endtask : ev
  task automatic pulse(ref logic s);
    @(negedge SYS_CLK);
    s = 1'b1;
    @(negedge SYS_CLK);
    s = 1'b0;
    repeat (2) @(negedge SYS_CLK);
  endtask : pulse
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      stop_test();
    end
  end
  // =====
  // tests
  initial begin
    logic [31:0] r, v;
    logic [31:0] rv[9];
    int c1, c5, c8, n5;
    logic [31:0] w;
    void'($urandom(2));
    repeat (16) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    RESET = 1'b0;
    for (int i = 0; i < 12; i++) begin
      rd(i[3:0], r);
      note("reset value", i[3:0] inside {4'h1, 4'h3, 4'h8} ? 32'hffff_ffff : 32'h0, r);
    end
    $display("end reset values");
    for (int i = 0; i < 9; i++) begin
      rv[i] = $urandom;
      wr(i[3:0], rv[i]);
    end
    SUP_MODE = 1'b0;
    wr(4'h0, ~rv[0]);
    rd(4'h0, r);
    note("locked read", 32'h0, r);
    SUP_MODE = 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(i[3:0], r);
      note("breakpoint reg", rv[i], r);
    end
    $display("end supervisor access");
    v = $urandom;
    i_host.xfer(1'b1, dbg_pkg::IDX_PC2, v, r);
    i_host.xfer(1'b0, dbg_pkg::IDX_ADDR, 32'h0, r);
    note("serial reply", v, r);
    rd(dbg_pkg::IDX_PC2, r);
    note("serial write", v, r);
    $display("end serial access");
    wr(dbg_pkg::IDX_ADDR, 32'h1234_5670);
    wr(dbg_pkg::IDX_ADDR_MASK, 32'h0000_000f);
    wr(dbg_pkg::IDX_TRIG_CTRL, 32'h0000_0101);
    ev(32'h1234_5771, 32'h0, 32'h0);
    note("halt on miss", 32'h0, 32'(CPU_HALT));
    ev(32'h1234_567b, 32'h0, 32'h0);
    note("halt", 32'h1, 32'(CPU_HALT));
    note("halted status", 32'hf, 32'(PROCESSOR_STATUS_BUS));
    note("all high", 32'h1, 32'(ALL_STATUS_HIGH));
    pulse(HALT_RELEASE);
    note("released", 32'h0, 32'(CPU_HALT));
    $display("end halt trigger");
    wr(dbg_pkg::IDX_PC_MASK, 32'h0000_0000);
    wr(dbg_pkg::IDX_TRIG_CTRL, 32'h0000_03d4);
    CPU_CRIT_IRQ = 1'b1;
    ev(32'h0, rv[2], ~rv[5]);
    ev(32'h0, ~rv[2], rv[5]);
    note("irq early", 32'h0, 32'(DEBUG_IRQ));
    ev(32'h0, rv[2], ~rv[5]);
    note("irq", 32'h1, 32'(DEBUG_IRQ));
    note("no halt", 32'h0, 32'(CPU_HALT));
    note("crit allow", 32'h1, 32'(CRIT_IRQ_ALLOW));
    pulse(DEBUG_IRQ_DONE);
    note("irq done", 32'h0, 32'(DEBUG_IRQ));
    wr(dbg_pkg::IDX_TRIG_CTRL, 32'h0);
    $display("end dual trigger");
    repeat (30) @(negedge SYS_CLK);
    v = $urandom;
    CPU_OBS = '{v, 32'h0, $urandom, 1'b1, 1'b1};
    @(negedge SYS_CLK);
    CPU_OBS.branch = 1'b0;
    c1 = 0;
    c5 = 0;
    c8 = 0;
    n5 = 0;
    w = 32'h0;
    for (int k = 0; k < 40; k++) begin
      @(negedge SYS_CLK);
      if (k == 0) CPU_OBS.valid = 1'b0;
      c1 += int'(PROCESSOR_STATUS_BUS === 4'h1);
      c5 += int'(PROCESSOR_STATUS_BUS === 4'h5);
      c8 += int'(PROCESSOR_STATUS_BUS === 4'h8);
      if (PROCESSOR_STATUS_BUS === 4'h5) n5 = 8;
      if (n5 > 0) begin
        w = {DEBUG_DATA_BUS, w[31:4]};
        n5--;
      end
    end
    note("branch starts", 32'h1, 32'(c5));
    note("insn starts", 32'h1, 32'(c1));
    note("operand cycles", 32'he, 32'(c8));
    note("branch target", v, w);
    @(posedge SYS_CLK);
    #1 note("trace clock", 32'h1, 32'(TRACE_CLOCK_OUT));
    @(negedge SYS_CLK);
    FULL_TRACE_PKG = 1'b0;
    ev(32'h0, 32'h0, 32'h0);
    note("small package bus", 32'h0, 32'(PROCESSOR_STATUS_BUS));
    @(posedge SYS_CLK);
    #1 note("small package clock", 32'h0, 32'(TRACE_CLOCK_OUT));
    $display("end trace");
    stop_test();
  end
endmodule : tb_core_debug_trigger_trace
`default_nettype wire
